// ===== rtl/nsls_pkg.sv
package nsls_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] NSLS_OFF_CMD = 8'h00;
  localparam logic [7:0] NSLS_OFF_CFG = 8'h04;
  localparam logic [7:0] NSLS_OFF_STAT = 8'h08;
  localparam logic [7:0] NSLS_OFF_IRQ_ST = 8'h0C;
  localparam logic [7:0] NSLS_OFF_IRQ_CLR = 8'h10;
  localparam logic [7:0] NSLS_OFF_IRQ_EN = 8'h14;

  // Command bits, write-only
  localparam int NSLS_CMD_INIT_OK = 0;
  localparam int NSLS_CMD_INIT_FAIL = 1;
  localparam int NSLS_CMD_START = 2;
  localparam int NSLS_CMD_PREOP = 3;
  localparam int NSLS_CMD_STOP = 4;

  // Event bits
  localparam int NSLS_EV_W = 4;
  localparam int NSLS_EV_PREOP = 0;
  localparam int NSLS_EV_OPER = 1;
  localparam int NSLS_EV_STOP = 2;
  localparam int NSLS_EV_CYCLE = 3;

  localparam logic [7:0] NSLS_DIP_CFG = 8'h00;
  localparam logic [3:0] NSLS_BURST_N = 4'h5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int NSLS_CLK_HZ = 40000000;
  localparam int NSLS_FAST_HALF_MS = 50;
  localparam int NSLS_SLOW_HALF_MS = 250;
  localparam int NSLS_CODE_HALF_MS = 500;
  localparam int NSLS_PAUSE_S_MS = 1000;
  localparam int NSLS_PAUSE_L_MS = 2000;
  localparam int NSLS_TICK_CYC = NSLS_CLK_HZ / 1000 * NSLS_FAST_HALF_MS;
  localparam logic [7:0] NSLS_SLOW_HALF = 8'(NSLS_SLOW_HALF_MS / NSLS_FAST_HALF_MS);
  localparam logic [7:0] NSLS_CODE_HALF = 8'(NSLS_CODE_HALF_MS / NSLS_FAST_HALF_MS);
  localparam logic [7:0] NSLS_PAUSE_S = 8'(NSLS_PAUSE_S_MS / NSLS_FAST_HALF_MS);
  localparam logic [7:0] NSLS_PAUSE_L = 8'(NSLS_PAUSE_L_MS / NSLS_FAST_HALF_MS);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    NSLS_ST_INIT = 4'b0001,
    NSLS_ST_PREOP = 4'b0010,
    NSLS_ST_OPER = 4'b0100,
    NSLS_ST_STOP = 4'b1000
  } nsls_stage_t;

  typedef enum logic [5:0] {
    NSLS_E_IDLE = 6'b000001,
    NSLS_E_BURST = 6'b000010,
    NSLS_E_PAUSE1 = 6'b000100,
    NSLS_E_CODE = 6'b001000,
    NSLS_E_PAUSE2 = 6'b010000,
    NSLS_E_TYPE = 6'b100000
  } nsls_erep_t;

  typedef struct packed {
    logic halt;
    logic run;
    logic txf;
    logic rxf;
    logic io_red;
    logic io_green;
  } nsls_led_t;

  localparam int NSLS_CFG_W = 21;
  typedef struct packed {
    logic [3:0] err_type;
    logic [3:0] err_code;
    logic spd_valid;
    logic [3:0] spd;
    logic dbus_err;
    logic hw_err;
    logic bus_idle;
    logic too_many;
    logic tx_err;
    logic rx_err;
    logic [1:0] mod_err;
  } nsls_cfg_t;

  localparam nsls_cfg_t NSLS_CFG_RST = '0;

  typedef struct packed {
    nsls_stage_t stage;
    nsls_erep_t erep;
    logic [31:0] tick_cnt;
    logic tick;
    logic fast_ph;
    logic [7:0] slow_cnt;
    logic slow_ph;
    logic [7:0] ph_cnt;
    logic [3:0] blink_cnt;
    nsls_cfg_t cfg;
    logic [NSLS_EV_W-1:0] irq_st;
    logic [NSLS_EV_W-1:0] irq_en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    nsls_led_t led;
    logic irq;
  } nsls_state_t;

endpackage

// ===== rtl/nsls_node_led.sv
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps

module nsls_node_led
  import nsls_pkg::*;
#(
  parameter int TICK_CYC = NSLS_TICK_CYC,
  parameter logic [7:0] SLOW_HALF = NSLS_SLOW_HALF,
  parameter logic [7:0] CODE_HALF = NSLS_CODE_HALF,
  parameter logic [7:0] PAUSE_S = NSLS_PAUSE_S,
  parameter logic [7:0] PAUSE_L = NSLS_PAUSE_L
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] dip_sw,
  output nsls_led_t leds,
  output logic irq
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  generate
    if (TICK_CYC < 1) begin : g_bad_tick
      $error("TICK_CYC must be at least one");
    end
    if (SLOW_HALF < 8'h02 || CODE_HALF < 8'h01 || CODE_HALF > 8'h7F) begin : g_bad_half
      $error("Blink half periods out of range");
    end
    if (PAUSE_S < 8'h01 || PAUSE_L <= PAUSE_S) begin : g_bad_pause
      $error("Long pause must exceed short pause");
    end
  endgenerate

  nsls_state_t st_r;
  nsls_state_t st_nxt;
  logic cfg_mode;
  logic setup;
  logic wr_acc;
  logic report;
  logic blink_ph;
  logic [7:0] hb;
  logic [7:0] hb2m1;
  logic [3:0] tgt;
  logic err_led_on;
  logic [NSLS_EV_W-1:0] ev;
  logic [4:0] cmd;

  assign cfg_mode = (dip_sw == NSLS_DIP_CFG);
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && st_r.pready && pwrite;
  assign cmd = (wr_acc && paddr == NSLS_OFF_CMD) ? pwdata[4:0] : 5'h00;
  assign report = (st_r.stage == NSLS_ST_STOP) && (st_r.cfg.err_code != 4'h0);
  assign blink_ph = (st_r.erep == NSLS_E_BURST) || (st_r.erep == NSLS_E_CODE)
                  || (st_r.erep == NSLS_E_TYPE);
  assign hb = (st_r.erep == NSLS_E_BURST) ? 8'h01 : CODE_HALF;
  assign hb2m1 = {hb[6:0], 1'b0} - 8'h01;
  assign tgt = (st_r.erep == NSLS_E_BURST) ? NSLS_BURST_N
             : (st_r.erep == NSLS_E_CODE) ? st_r.cfg.err_code : st_r.cfg.err_type;
  assign err_led_on = blink_ph && (st_r.ph_cnt < hb);

  always_comb begin
    st_nxt = st_r;
    ev = '0;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;

    // ----------------------------------------------------------------
    // Timebase: one tick per fast half period
    // ----------------------------------------------------------------
    st_nxt.tick = 1'b0;
    if (st_r.tick_cnt == 32'(TICK_CYC - 1)) begin
      st_nxt.tick_cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 32'h1;
    end
    if (st_r.tick) begin
      st_nxt.fast_ph = !st_r.fast_ph;
      if (st_r.slow_cnt == SLOW_HALF - 8'h01) begin
        st_nxt.slow_cnt = '0;
        st_nxt.slow_ph = !st_r.slow_ph;
      end else begin
        st_nxt.slow_cnt = st_r.slow_cnt + 8'h01;
      end
    end

    // ----------------------------------------------------------------
    // Node stage
    // ----------------------------------------------------------------
    case (st_r.stage)
      NSLS_ST_INIT: begin
        if (cmd[NSLS_CMD_INIT_FAIL]) begin
          st_nxt.stage = NSLS_ST_STOP;
        end else if (cmd[NSLS_CMD_INIT_OK]) begin
          st_nxt.stage = NSLS_ST_PREOP;
        end
      end
      NSLS_ST_PREOP: begin
        if (cmd[NSLS_CMD_STOP]) begin
          st_nxt.stage = NSLS_ST_STOP;
        end else if (cmd[NSLS_CMD_START]) begin
          st_nxt.stage = NSLS_ST_OPER;
        end
      end
      NSLS_ST_OPER: begin
        if (cmd[NSLS_CMD_STOP]) begin
          st_nxt.stage = NSLS_ST_STOP;
        end else if (cmd[NSLS_CMD_PREOP]) begin
          st_nxt.stage = NSLS_ST_PREOP;
        end
      end
      NSLS_ST_STOP: begin
        if (cmd[NSLS_CMD_PREOP]) begin
          st_nxt.stage = NSLS_ST_PREOP;
        end
      end
      default: st_nxt.stage = NSLS_ST_INIT;
    endcase
    if (st_nxt.stage != st_r.stage) begin
      ev[NSLS_EV_PREOP] = (st_nxt.stage == NSLS_ST_PREOP);
      ev[NSLS_EV_OPER] = (st_nxt.stage == NSLS_ST_OPER);
      ev[NSLS_EV_STOP] = (st_nxt.stage == NSLS_ST_STOP);
    end

    // ----------------------------------------------------------------
    // Error report sequencer
    // ----------------------------------------------------------------
    if (!report) begin
      st_nxt.erep = NSLS_E_IDLE;
      st_nxt.ph_cnt = '0;
      st_nxt.blink_cnt = '0;
    end else begin
      case (st_r.erep)
        NSLS_E_IDLE: begin
          st_nxt.erep = NSLS_E_BURST;
          st_nxt.ph_cnt = '0;
          st_nxt.blink_cnt = '0;
        end
        NSLS_E_BURST, NSLS_E_CODE, NSLS_E_TYPE: begin
          if (st_r.tick) begin
            if (st_r.ph_cnt == hb2m1) begin
              st_nxt.ph_cnt = '0;
              // A zero count still gives one blink, keeping the cycle visible
              if (st_r.blink_cnt + 4'h1 >= tgt) begin
                st_nxt.blink_cnt = '0;
                case (st_r.erep)
                  NSLS_E_BURST: st_nxt.erep = NSLS_E_PAUSE1;
                  NSLS_E_CODE: st_nxt.erep = NSLS_E_PAUSE2;
                  default: begin
                    st_nxt.erep = NSLS_E_BURST;
                    ev[NSLS_EV_CYCLE] = 1'b1;
                  end
                endcase
              end else begin
                st_nxt.blink_cnt = st_r.blink_cnt + 4'h1;
              end
            end else begin
              st_nxt.ph_cnt = st_r.ph_cnt + 8'h01;
            end
          end
        end
        NSLS_E_PAUSE1: begin
          if (st_r.tick) begin
            if (st_r.ph_cnt == PAUSE_S - 8'h01) begin
              st_nxt.ph_cnt = '0;
              st_nxt.erep = NSLS_E_CODE;
            end else begin
              st_nxt.ph_cnt = st_r.ph_cnt + 8'h01;
            end
          end
        end
        NSLS_E_PAUSE2: begin
          if (st_r.tick) begin
            if (st_r.ph_cnt == PAUSE_L - 8'h01) begin
              st_nxt.ph_cnt = '0;
              st_nxt.erep = NSLS_E_TYPE;
            end else begin
              st_nxt.ph_cnt = st_r.ph_cnt + 8'h01;
            end
          end
        end
        default: st_nxt.erep = NSLS_E_IDLE;
      endcase
    end

    // ----------------------------------------------------------------
    // Indicators
    // ----------------------------------------------------------------
    st_nxt.led = '0;
    if (cfg_mode) begin
      st_nxt.led.halt = st_r.cfg.spd[0];
      st_nxt.led.run = st_r.cfg.spd[1];
      st_nxt.led.txf = st_r.cfg.spd_valid ? st_r.cfg.spd[2] : st_r.fast_ph;
      st_nxt.led.rxf = st_r.cfg.spd[3];
    end else begin
      case (st_r.stage)
        NSLS_ST_INIT: begin
          // Orange is red and green together
          st_nxt.led.io_red = st_r.fast_ph;
          st_nxt.led.io_green = st_r.fast_ph;
        end
        NSLS_ST_PREOP: begin
          case (st_r.cfg.mod_err)
            2'h1: st_nxt.led.run = st_r.fast_ph;
            2'h2: begin
              st_nxt.led.run = st_r.fast_ph;
              st_nxt.led.halt = st_r.fast_ph;
            end
            2'h3: st_nxt.led.halt = st_r.fast_ph;
            default: st_nxt.led.run = st_r.slow_ph;
          endcase
        end
        NSLS_ST_OPER: st_nxt.led.run = 1'b1;
        NSLS_ST_STOP: st_nxt.led.halt = 1'b1;
        default: st_nxt.led = '0;
      endcase
      if (st_r.stage != NSLS_ST_INIT) begin
        if (st_r.cfg.too_many) begin
          st_nxt.led.txf = st_r.fast_ph;
          st_nxt.led.rxf = st_r.fast_ph;
        end else begin
          st_nxt.led.txf = st_r.cfg.tx_err;
          st_nxt.led.rxf = st_r.cfg.rx_err;
        end
      end
      if (st_r.stage == NSLS_ST_STOP) begin
        if (report) begin
          st_nxt.led.io_red = err_led_on;
        end else if (st_r.cfg.hw_err) begin
          st_nxt.led.io_red = 1'b1;
        end else begin
          st_nxt.led.io_red = st_r.slow_ph;
        end
      end else if (st_r.stage != NSLS_ST_INIT) begin
        if (st_r.cfg.hw_err) begin
          st_nxt.led.io_red = 1'b1;
        end else if (st_r.cfg.dbus_err) begin
          st_nxt.led.io_red = st_r.slow_ph;
        end else if (!st_r.cfg.bus_idle) begin
          st_nxt.led.io_green = 1'b1;
        end
      end
    end

    // ----------------------------------------------------------------
    // APB slave: answer in the first access cycle
    // ----------------------------------------------------------------
    if (setup) begin
      st_nxt.pready = 1'b1;
      st_nxt.prdata = '0;
      case (paddr)
        NSLS_OFF_CMD, NSLS_OFF_IRQ_CLR: st_nxt.prdata = '0;
        NSLS_OFF_CFG: st_nxt.prdata = {{(32 - NSLS_CFG_W){1'b0}}, st_r.cfg};
        NSLS_OFF_STAT: st_nxt.prdata = {15'h0000, cfg_mode, st_r.erep, st_r.stage, st_r.led};
        NSLS_OFF_IRQ_ST: st_nxt.prdata = {28'h0000000, st_r.irq_st};
        NSLS_OFF_IRQ_EN: st_nxt.prdata = {28'h0000000, st_r.irq_en};
        default: st_nxt.pslverr = 1'b1;
      endcase
    end
    if (wr_acc && paddr == NSLS_OFF_CFG) begin
      st_nxt.cfg = pwdata[NSLS_CFG_W-1:0];
    end
    if (wr_acc && paddr == NSLS_OFF_IRQ_EN) begin
      st_nxt.irq_en = pwdata[NSLS_EV_W-1:0];
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    // A new event in the clearing cycle survives the clear
    if (wr_acc && paddr == NSLS_OFF_IRQ_CLR) begin
      st_nxt.irq_st = (st_r.irq_st & ~pwdata[NSLS_EV_W-1:0]) | ev;
    end else begin
      st_nxt.irq_st = st_r.irq_st | ev;
    end
    st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{stage: NSLS_ST_INIT, erep: NSLS_E_IDLE, cfg: NSLS_CFG_RST,
                led: '0, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign leds = st_r.led;
  assign irq = st_r.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_init_ok;
    st_r.stage == NSLS_ST_INIT && cmd[NSLS_CMD_INIT_OK] && !cmd[NSLS_CMD_INIT_FAIL];
  endsequence

  sequence s_pause1_end;
    st_r.erep == NSLS_E_PAUSE1 && report && st_r.tick && st_r.ph_cnt == PAUSE_S - 8'h01;
  endsequence

  sequence s_pause2_end;
    st_r.erep == NSLS_E_PAUSE2 && report && st_r.tick && st_r.ph_cnt == PAUSE_L - 8'h01;
  endsequence

  a_init_to_preop: assert property (s_init_ok |=> st_r.stage == NSLS_ST_PREOP)
    else $error("init success did not reach pre-operative");

  a_init_dark: assert property ((st_r.stage == NSLS_ST_INIT && !cfg_mode)
      |=> !leds.halt && !leds.run && !leds.txf && !leds.rxf)
    else $error("indicators lit while initializing");

  a_init_orange: assert property ((st_r.stage == NSLS_ST_INIT && !cfg_mode)
      |=> leds.io_red == leds.io_green && leds.io_red == $past(st_r.fast_ph))
    else $error("bus LED not blinking orange in init");

  a_oper_steady: assert property ((st_r.stage == NSLS_ST_OPER && !cfg_mode)
      |=> leds.run && !leds.halt)
    else $error("operative stage indicators wrong");

  a_stop_halt: assert property ((st_r.stage == NSLS_ST_STOP && !cfg_mode)
      |=> leds.halt && !leds.run)
    else $error("stop stage indicators wrong");

  a_preop_green: assert property ((st_r.stage == NSLS_ST_PREOP && !cfg_mode
      && st_r.cfg == NSLS_CFG_RST) |=> leds.io_green && !leds.io_red && !leds.halt)
    else $error("pre-operative bus LED not green");

  a_cfg_mirror: assert property (cfg_mode |=> leds.halt == $past(st_r.cfg.spd[0])
      && leds.run == $past(st_r.cfg.spd[1]) && leds.rxf == $past(st_r.cfg.spd[3]))
    else $error("config mode speed display wrong");

  a_rx_fault: assert property ((!cfg_mode && st_r.stage != NSLS_ST_INIT
      && st_r.cfg.rx_err && !st_r.cfg.too_many) |=> leds.rxf)
    else $error("receive fault not shown");

  a_burst_on: assert property ((st_r.erep == NSLS_E_BURST && st_r.ph_cnt == 8'h00
      && report && !cfg_mode) |=> leds.io_red)
    else $error("burst blink missing");

  a_code_start: assert property (s_pause1_end |=> st_r.erep == NSLS_E_CODE
      ##1 (leds.io_red || !report || cfg_mode))
    else $error("code sequence did not follow short pause");

  a_type_start: assert property (s_pause2_end |=> st_r.erep == NSLS_E_TYPE)
    else $error("type sequence did not follow long pause");

  a_cycle_event: assert property ((st_r.erep == NSLS_E_TYPE
      && st_nxt.erep == NSLS_E_BURST) |=> st_r.irq_st[NSLS_EV_CYCLE])
    else $error("report restart event not latched");

  a_stop_event: assert property ((st_r.stage != NSLS_ST_STOP && st_nxt.stage == NSLS_ST_STOP)
      |=> st_r.irq_st[NSLS_EV_STOP])
    else $error("stop event not latched");

endmodule // nsls_node_led

// ===== test/nsls_led_viewer.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Operator's eye on the indicator row
// ----------------------------------------------------------------
module nsls_led_viewer
  import nsls_pkg::*;
(
  input wire logic pclk,
  input wire logic clr,
  input wire nsls_led_t leds
);
  // Dark stretch longer than any in-sequence off phase splits groups
  localparam int GAP_MIN = 12;
  int tog[6];
  int on[6];
  int org;
  int cnt;
  int gap;
  int wid;
  int lg;
  int gw;
  int grp_q[$];
  int gap_q[$];
  int wid_q[$];
  logic [5:0] prev;

  always @(posedge pclk) begin
    if (clr) begin
      foreach (tog[i]) begin
        tog[i] = 0;
        on[i] = 0;
      end
      org = 0;
      cnt = 0;
      gap = 999;
      wid = 0;
      grp_q.delete();
      gap_q.delete();
      wid_q.delete();
    end else begin
      foreach (tog[i]) begin
        tog[i] += int'(leds[i] ^ prev[i]);
        on[i] += int'(leds[i]);
      end
      org += int'(leds.io_red & leds.io_green);
      if (leds.io_red && !prev[1]) begin
        if (gap > GAP_MIN && cnt != 0) begin
          grp_q.push_back(cnt);
          gap_q.push_back(gap);
          cnt = 0;
        end
        cnt++;
        lg = gap;
        gap = 0;
        wid = 0;
      end
      if (leds.io_red) wid++;
      else gap++;
      // No pause before the next burst, so a width change splits too
      if (!leds.io_red && prev[1]) begin
        if (cnt > 1 && wid != gw) begin
          grp_q.push_back(cnt - 1);
          gap_q.push_back(lg);
          cnt = 1;
        end
        // Only the first pulse of a group tells its rate
        if (cnt == 1) begin
          wid_q.push_back(wid);
          gw = wid;
        end
      end
    end
    prev = leds;
  end
endmodule // nsls_led_viewer

// ===== test/test_node_status_led_sequencer.sv
`timescale 1ns/1ps

module test_node_status_led_sequencer;
  import nsls_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, clr, er, found;
  logic [7:0] paddr, dip_sw;
  logic [31:0] pwdata, prdata, rd;
  nsls_led_t leds;
  int miscompares, checks, slow_tog;
  logic [31:0] ocfg[7] = '{32'h0, 32'h4, 32'h8, 32'h10, 32'h20, 32'h40, 32'h80};
  logic [5:0] oson[7] = '{6'h11, 6'h15, 6'h19, 6'h11, 6'h10, 6'h12, 6'h10};
  logic [5:0] obl[7] = '{6'h00, 6'h00, 6'h00, 6'h0C, 6'h00, 6'h00, 6'h02};

  // Short tick keeps a full report cycle to 160 clocks
  nsls_node_led #(.TICK_CYC(4), .SLOW_HALF(8'h03), .CODE_HALF(8'h02), .PAUSE_S(8'h04),
    .PAUSE_L(8'h06)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dip_sw(dip_sw), .leds(leds), .irq(irq));
  nsls_led_viewer eye (.pclk(pclk), .clr(clr), .leds(leds));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task give_verdict;
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      miscompares++;
    end
  endtask

  task ck1(input string nm, input logic b);
    chk(nm, 32'h1, {31'h0, b});
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      ck1("pready", pready);
      give_verdict();
    end
  endtask

  task do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task stage_is(input logic [3:0] e);
    apb(1'b0, NSLS_OFF_STAT, 32'h0);
    chk("stage", {28'h0, e}, {28'h0, rd[9:6]});
  endtask

  task watch(input int n);
    @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  // Steady bits lit every cycle, blink bits toggling, the rest dark
  task view(input string nm, input logic [5:0] son, input logic [5:0] bl);
    watch(96);
    for (int i = 0; i < 6; i++) begin
      if (bl[i]) ck1(nm, eye.tog[i] >= 2);
      else chk(nm, son[i] ? 32'h60 : 32'h0, eye.on[i]);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    dip_sw = 8'h05;
    clr = 1'b0;
    miscompares = 0;
    checks = 0;
    do_reset();
    stage_is(4'h1);
    view("init", 6'h00, 6'h03);
    ck1("orange", eye.org > 0);
    apb(1'b0, NSLS_OFF_CFG, 32'h0);
    chk("cfg_rst", 32'h0, rd);
    apb(1'b0, NSLS_OFF_IRQ_EN, 32'h0);
    chk("en_rst", 32'h0, rd);
    apb(1'b0, 8'h18, 32'h0);
    ck1("unmap_err", er);
    chk("unmap_data", 32'h0, rd);
    apb(1'b1, NSLS_OFF_STAT, 32'hFFFFFFFF);
    stage_is(4'h1);
    apb(1'b1, NSLS_OFF_CMD, 32'h2);
    stage_is(4'h8);
    view("fail", 6'h20, 6'h02);
    do_reset();
    stage_is(4'h1);
    apb(1'b1, NSLS_OFF_CMD, 32'h1);
    stage_is(4'h2);
    apb(1'b0, NSLS_OFF_IRQ_ST, 32'h0);
    chk("irq_st", 32'h1, rd);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, NSLS_OFF_IRQ_EN, 32'h1);
    repeat (2) @(posedge pclk);
    ck1("irq_on", irq);
    apb(1'b1, NSLS_OFF_IRQ_CLR, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_off", 32'h0, {31'h0, irq});
    apb(1'b1, NSLS_OFF_IRQ_EN, 32'hF);
    view("preop", 6'h01, 6'h10);
    slow_tog = eye.tog[4];
    for (int m = 1; m < 4; m++) begin
      apb(1'b1, NSLS_OFF_CFG, 32'(m));
      view("mod_err", 6'h01, m == 1 ? 6'h10 : m == 2 ? 6'h30 : 6'h20);
      ck1("fast", eye.tog[m == 3 ? 5 : 4] > slow_tog);
    end
    apb(1'b1, NSLS_OFF_CFG, 32'h0);
    apb(1'b1, NSLS_OFF_CMD, 32'h4);
    stage_is(4'h4);
    apb(1'b0, NSLS_OFF_IRQ_ST, 32'h0);
    chk("irq_oper", 32'h2, rd);
    ck1("irq_lvl", irq);
    apb(1'b1, NSLS_OFF_IRQ_CLR, 32'hF);
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, NSLS_OFF_CFG, ocfg[i]);
      view("oper", oson[i], obl[i]);
    end
    ck1("dbus_blink", eye.tog[1] > 0);
    apb(1'b1, NSLS_OFF_CFG, 32'h0);
    apb(1'b1, NSLS_OFF_CMD, 32'h10);
    stage_is(4'h8);
    view("stop", 6'h20, 6'h02);
    // Code 2, type 3
    apb(1'b1, NSLS_OFF_CFG, 32'h64000);
    watch(600);
    found = 1'b0;
    for (int i = 1; i + 3 < eye.grp_q.size(); i++) begin
      if (!found && eye.grp_q[i] == 5) begin
        found = 1'b1;
        chk("code_cnt", 32'h2, eye.grp_q[i + 1]);
        chk("type_cnt", 32'h3, eye.grp_q[i + 2]);
        chk("again", 32'h5, eye.grp_q[i + 3]);
        ck1("pause_long", eye.gap_q[i + 1] > eye.gap_q[i]);
        ck1("code_slow", eye.wid_q[i + 1] > eye.wid_q[i]);
      end
    end
    ck1("report", found);
    apb(1'b0, NSLS_OFF_IRQ_ST, 32'h0);
    ck1("restart_ev", rd[NSLS_EV_CYCLE]);
    apb(1'b1, NSLS_OFF_CFG, 32'h40);
    view("stop_hw", 6'h22, 6'h00);
    // Config mode: run and rxf stored, halt must yield despite stop
    apb(1'b1, NSLS_OFF_CFG, 32'h1A00);
    dip_sw <= 8'h00;
    watch(96);
    apb(1'b0, NSLS_OFF_STAT, 32'h0);
    ck1("cfg_mode", rd[16]);
    chk("halt_sw1", 32'h0, eye.on[5]);
    ck1("run_sw2", eye.on[4] > 0);
    chk("txf_sw3", 32'h0, eye.on[3]);
    ck1("rxf_sw4", eye.on[2] > 0);
    apb(1'b1, NSLS_OFF_CFG, 32'h0A00);
    watch(96);
    ck1("unstored", eye.tog[3] >= 2);
    @(posedge pclk);
    dip_sw <= 8'h05;
    apb(1'b1, NSLS_OFF_CMD, 32'h8);
    stage_is(4'h2);
    give_verdict();
  end
endmodule // test_node_status_led_sequencer
